// ---- scan_cycle_mode_sequencer_tb_top.sv ----
// Purpose: Self-checking bench of the scan cycle sequencer.
// Assumes: Clock enable high except in the retain test; one AXI4-Lite transfer at a time.
// Notes:   A short millisecond count keeps watchdog trips brief.
`timescale 1ns/1ps
module scan_cycle_mode_sequencer_tb_top;
	import scs_pkg::*;
	// --------------------
	// Signals
	// --------------------
	logic        sys_clk, arst_n, ce;
	logic [7:0]  s_awaddr, s_araddr;
	logic        s_awvalid, s_awready, s_wvalid, s_wready;
	logic [31:0] s_wdata, s_rdata;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	logic        s_bvalid, s_bready, s_arvalid, s_arready;
	logic        s_rvalid, s_rready;
	logic [15:0] field_in, field_out;
	logic        mode_switch_run, usb_low_power, fatal_in, nonfatal_in;
	logic        run_mode, fault;
	int          error_cnt, total_checks;

	scs_top #(.CYC_PER_MS(4)) i_scs_top (.sys_clk(sys_clk),
		.arst_n(arst_n), .ce(ce), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
		.s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .field_in(field_in),
		.field_out(field_out), .mode_switch_run(mode_switch_run),
		.usb_low_power(usb_low_power), .fatal_in(fatal_in),
		.nonfatal_in(nonfatal_in), .run_mode(run_mode), .fault(fault));
	scs_field_model i_scs_field_model (.sys_clk(sys_clk),
		.field_out(field_out), .field_in(field_in),
		.mode_switch_run(mode_switch_run));

	// Clock at 40 ns period.
	always #20 sys_clk = ~sys_clk;

	// --------------------
	// Compare and bus tasks
	// --------------------
	// Compares a data word.
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Compares a bus response code.
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Writes one word; address and data go out together.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_awvalid && s_awready) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready) s_wvalid <= 1'b0;
		end while (!(s_bvalid && s_bready) && n < 50);
		s_bready <= 1'b0;
		chk_resp((n < 50) ? s_bresp : 2'h3, er);
	endtask
	// Reads one word and compares the masked value and response.
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_arvalid && s_arready) s_arvalid <= 1'b0;
		end while (!(s_rvalid && s_rready) && n < 50);
		s_rready <= 1'b0;
		chk_resp((n < 50) ? s_rresp : 2'h3, er);
		chk_word(s_rdata & m, e);
	endtask
	// Counts scans over a fixed span through the system data counter.
	task automatic scan_rate(input int cyc, input logic [31:0] exp);
		logic [31:0] a;
		a = 32'h0;
		@(posedge sys_clk);
		s_araddr  <= OFF_SYS_DAT;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		@(posedge sys_clk);
		s_arvalid <= 1'b0;
		@(posedge sys_clk);
		a = s_rdata;
		s_rready <= 1'b0;
		repeat (cyc - 1) @(posedge sys_clk);
		rd(OFF_SYS_DAT, 32'hFFFFFFFF, a + exp, RESP_OK);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Applies reset for three cycles and lets the sync release.
	task automatic do_reset();
		arst_n <= 1'b0;
		wait_cyc(3);
		arst_n <= 1'b1;
		wait_cyc(4);
	endtask
	// Pulses one error input for a cycle.
	task automatic pulse(input logic fat);
		@(posedge sys_clk);
		if (fat) fatal_in <= 1'b1;
		else nonfatal_in <= 1'b1;
		@(posedge sys_clk);
		fatal_in    <= 1'b0;
		nonfatal_in <= 1'b0;
		wait_cyc(3);
	endtask

	// --------------------
	// Scenarios
	// --------------------
	// Stop mode: inputs sampled, outputs off, software run refused.
	task automatic t_stop();
		chk_word({30'h0, run_mode, fault}, 32'h0);
		rd(OFF_SLEN, 32'hFF, 32'h4, RESP_OK);
		rd(OFF_WDT, 32'h3FFF, 32'hC8, RESP_OK);
		i_scs_field_model.set_inputs(16'hA5C3);
		wait_cyc(12);
		rd(OFF_IN_IMG, 32'hFFFF, 32'hA5C3, RESP_OK);
		wr(OFF_CTRL, 32'h1, RESP_OK);
		wait_cyc(12);
		chk_word({31'h0, run_mode}, 32'h0);
		chk_word({16'h0, field_out}, 32'h0);
		scan_rate(40, 32'd10);
		$display("test stop done");
	endtask
	// Run entry, solving, write-out, override and scan lengths.
	task automatic t_run();
		usb_low_power <= 1'b1;
		i_scs_field_model.set_switch(1'b1);
		wait_cyc(12);
		chk_word({31'h0, run_mode}, 32'h0);
		rd(OFF_STAT, 32'h31, 32'h30, RESP_OK);
		usb_low_power <= 1'b0;
		wr(OFF_PROG, 32'h00FFFFFF, RESP_OK);
		wr(OFF_CTRL, 32'h1, RESP_OK);
		i_scs_field_model.set_inputs(16'h1234);
		wait_cyc(30);
		chk_word({31'h0, run_mode}, 32'h1);
		rd(OFF_OUT_IMG, 32'hFFFF, 32'h12CB, RESP_OK);
		chk_word({16'h0, i_scs_field_model.last_out}, 32'h12CB);
		wr(OFF_OVR_IN, 32'h00FF, RESP_OK);
		i_scs_field_model.set_inputs(16'hABCD);
		wait_cyc(30);
		rd(OFF_IN_IMG, 32'hFFFF, 32'hAB34, RESP_OK);
		chk_word({16'h0, field_out}, 32'hABCB);
		wr(OFF_OVR_IN, 32'h0, RESP_OK);
		scan_rate(100, 32'd10);
		wr(OFF_CTRL, 32'h4, RESP_OK);
		scan_rate(110, 32'd10);
		wr(OFF_CTRL, 32'h0, RESP_OK);
		$display("test run done");
	endtask
	// Errors of both levels, software stop and the watchdog.
	task automatic t_errors();
		pulse(1'b0);
		chk_word({31'h0, run_mode}, 32'h1);
		rd(OFF_STAT, 32'h7, 32'h5, RESP_OK);
		wr(OFF_CTRL, 32'h2, RESP_OK);
		i_scs_field_model.set_inputs(16'h0F0F);
		wait_cyc(12);
		chk_word({15'h0, run_mode, field_out}, 32'h0);
		rd(OFF_IN_IMG, 32'hFFFF, 32'h0F0F, RESP_OK);
		wr(OFF_CTRL, 32'h9, RESP_OK);
		wr(OFF_CTRL, 32'h1, RESP_OK);
		wait_cyc(30);
		chk_word({15'h0, run_mode, field_out}, 32'h10FF0);
		pulse(1'b1);
		chk_word({14'h0, fault, run_mode, field_out}, 32'h20000);
		wr(OFF_CTRL, 32'h8, RESP_OK);
		wr(OFF_CTRL, 32'h1, RESP_OK);
		wr(OFF_SLEN, 32'hFF, RESP_OK);
		wr(OFF_WDT, 32'h5, RESP_OK);
		wait_cyc(60);
		chk_word({15'h0, run_mode, field_out}, 32'h0);
		rd(OFF_STAT, 32'h9, 32'h8, RESP_OK);
		wr(OFF_SLEN, 32'h4, RESP_OK);
		wr(OFF_STAT, 32'h0, RESP_ERR);
		rd(8'hFC, 32'hFFFFFFFF, 32'h0, RESP_ERR);
		$display("test errors done");
	endtask
	// Retentive word survives a second reset; the output image is cleared.
	task automatic t_retain();
		wr(OFF_RETAIN, 32'h5A5A0F0F, RESP_OK);
		i_scs_field_model.set_switch(1'b0);
		wait_cyc(2);
		do_reset();
		rd(OFF_RETAIN, 32'hFFFFFFFF, 32'h5A5A0F0F, RESP_OK);
		rd(OFF_OUT_IMG, 32'hFFFF, 32'h0, RESP_OK);
		chk_word({15'h0, run_mode, field_out}, 32'h0);
		// A single byte lane only replaces the low byte.
		s_wstrb <= 4'h1;
		wr(OFF_RETAIN, 32'hFFFFFFFF, RESP_OK);
		s_wstrb <= 4'hF;
		rd(OFF_RETAIN, 32'hFFFFFFFF, 32'h5A5A0FFF, RESP_OK);
		// A low clock enable freezes the switch edge until it rises.
		ce <= 1'b0;
		i_scs_field_model.set_switch(1'b1);
		wait_cyc(10);
		chk_word({31'h0, run_mode}, 32'h0);
		ce <= 1'b1;
		wait_cyc(5);
		chk_word({31'h0, run_mode}, 32'h1);
		$display("test retain done");
	endtask

	// Prints counts and verdict, then ends the run.
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Drives inputs at time zero and runs the scenarios in order.
	initial begin
		{sys_clk, ce, s_awvalid, s_wvalid, s_bready} = 5'b01000;
		{s_arvalid, s_rready, usb_low_power, fatal_in} = 4'h0;
		{arst_n, nonfatal_in, error_cnt, total_checks} = '0;
		{s_awaddr, s_araddr, s_wdata} = '0;
		s_wstrb = 4'hF;
		do_reset();
		t_stop();
		t_run();
		t_errors();
		t_retain();
		end_of_test();
	end
	// Cuts a hang short after far more time than the tests need.
	initial begin
		#400000;
		error_cnt++;
		end_of_test();
	end
endmodule // scan_cycle_mode_sequencer_tb_top

// ---- scs_field_model.sv ----
// Purpose: Field I/O and mode switch model facing the sequencer.
// Assumes: Inputs change by non-blocking assignment after a rising edge.
// Notes:   Output terminals are only watched, never driven.
`timescale 1ns/1ps
module scs_field_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] field_out,
	output logic [15:0]      field_in,
	output logic             mode_switch_run
);
	logic [15:0] last_out;

	// Points start off and the switch starts at Stop.
	initial begin
		field_in        = 16'h0000;
		mode_switch_run = 1'b0;
	end

	// Sets the input points just after an edge.
	task automatic set_inputs(input logic [15:0] v);
		@(posedge sys_clk);
		field_in <= v;
	endtask

	// Moves the switch; software requests only count at Run.
	task automatic set_switch(input logic run);
		@(posedge sys_clk);
		mode_switch_run <= run;
	endtask

	// Latches what the output terminals show, one cycle late.
	always @(posedge sys_clk) begin
		last_out <= field_out;
	end
endmodule // scs_field_model

// ---- scs_pkg.sv ----
// Purpose: Shared constants and types of the scan cycle sequencer.
// Assumes: AXI4-Lite register access, one clock at 25 MHz.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package scs_pkg;
	// -------------------------------------------------------------
	// Widths and register map
	// -------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int IMG_W  = 16;
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STAT    = 8'h04;
	localparam logic [7:0] OFF_IN_IMG  = 8'h08;
	localparam logic [7:0] OFF_OUT_IMG = 8'h0C;
	localparam logic [7:0] OFF_FRC_IN  = 8'h10;
	localparam logic [7:0] OFF_FRC_OUT = 8'h14;
	localparam logic [7:0] OFF_OVR_IN  = 8'h18;
	localparam logic [7:0] OFF_OVR_OUT = 8'h1C;
	localparam logic [7:0] OFF_PROG    = 8'h20;
	localparam logic [7:0] OFF_WDT     = 8'h24;
	localparam logic [7:0] OFF_SCAN    = 8'h28;
	localparam logic [7:0] OFF_SYS_DAT = 8'h2C;
	localparam logic [7:0] OFF_SYS_REL = 8'h30;
	localparam logic [7:0] OFF_SLEN    = 8'h34;
	localparam logic [7:0] OFF_RETAIN  = 8'h38;
	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int CTL_RUN  = 0;
	localparam int CTL_STOP = 1;
	localparam int CTL_IMM  = 2;
	localparam int CTL_CLR  = 3;
	localparam int ST_RUN   = 0;
	localparam int ST_FATAL = 1;
	localparam int ST_NONF  = 2;
	localparam int ST_WDT   = 3;
	localparam int ST_LOWP  = 4;
	localparam int ST_SW    = 5;
	// -------------------------------------------------------------
	// Reset values, limits and timing
	// -------------------------------------------------------------
	localparam logic [13:0] WDT_DEF_MS = 14'h00C8;
	localparam logic [13:0] WDT_MIN_MS = 14'h0005;
	localparam logic [13:0] WDT_MAX_MS = 14'h2710;
	localparam logic [7:0]  SLEN_RST   = 8'h04;
	localparam int CLK_HZ     = 25000000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int AVG_SH     = 3;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [2:0] {
		SEG_INIT, SEG_READ, SEG_SERVICE, SEG_SYSTEM,
		SEG_SOLVE, SEG_WRITE, SEG_DIAG
	} scs_seg_t;
endpackage

// ---- scs_top.sv ----
// Purpose: Scan cycle and Run/Stop mode sequencer of a small controller.
// Assumes: Field inputs, switch and error pins are synchronous to sys_clk.
// Notes:   Program solving is a mask-and-invert of the solver source.
`timescale 1ns/1ps
module scs_top #(
	parameter int unsigned CYC_PER_MS = scs_pkg::CYC_PER_MS
) (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	input  wire logic [15:0] field_in,
	output logic [15:0]      field_out,
	input  wire logic        mode_switch_run,
	input  wire logic        usb_low_power,
	input  wire logic        fatal_in,
	input  wire logic        nonfatal_in,
	output logic             run_mode,
	output logic             fault
);
	import scs_pkg::*;

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	logic        rst_meta, rst_n;
	logic [7:0]  aw_addr;
	logic [31:0] w_data, wv, retain;
	logic [3:0]  w_strb;
	logic        wr_en, wr_hit, rd_hit;
	logic [32:0] rd_word, old_word;
	logic        imm_mode, req_run, req_stop, err_clr, sw_q;
	logic        fatal_flag, nonf_flag, wdt_err, wdt_trip;
	logic [13:0] wdt_ms;
	logic [7:0]  solve_len, solve_cnt;
	logic [31:0] prog, wdt_cnt, wdt_lim, scan_cnt, scan_avg;
	logic [31:0] sys_data;
	logic [6:0]  sys_relay;
	logic [15:0] in_image, out_image, ovr_in, ovr_out, solved;
	logic [15:0] fin_val, fin_msk, fout_val, fout_msk;
	logic        fin_pend, fout_pend, first_scan;
	scs_seg_t    seg;

	// Merges written byte lanes into the previous register value.
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Register read decode; bit 32 marks a mapped address.
	function automatic logic [32:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		logic        h;
		v = 32'h0000_0000;
		h = 1'b1;
		if (a == OFF_CTRL) begin
			v[CTL_IMM] = imm_mode;
		end else if (a == OFF_STAT) begin
			v[ST_RUN] = run_mode;
			v[ST_FATAL] = fatal_flag;
			v[ST_NONF] = nonf_flag;
			v[ST_WDT] = wdt_err;
			v[ST_LOWP] = usb_low_power;
			v[ST_SW] = mode_switch_run;
		end else if (a == OFF_IN_IMG) begin
			v[15:0] = in_image;
		end else if (a == OFF_OUT_IMG) begin
			v[15:0] = out_image;
		end else if (a == OFF_FRC_IN) begin
			v = {fin_msk, fin_val};
		end else if (a == OFF_FRC_OUT) begin
			v = {fout_msk, fout_val};
		end else if (a == OFF_OVR_IN) begin
			v[15:0] = ovr_in;
		end else if (a == OFF_OVR_OUT) begin
			v[15:0] = ovr_out;
		end else if (a == OFF_PROG) begin
			v = prog;
		end else if (a == OFF_WDT) begin
			v[13:0] = wdt_ms;
		end else if (a == OFF_SCAN) begin
			v = scan_avg;
		end else if (a == OFF_SYS_DAT) begin
			v = sys_data;
		end else if (a == OFF_SYS_REL) begin
			v[6:0] = sys_relay;
		end else if (a == OFF_SLEN) begin
			v[7:0] = solve_len;
		end else if (a == OFF_RETAIN) begin
			v = retain;
		end else begin
			h = 1'b0;
		end
		return {h, v};
	endfunction

	// -------------------------------------------------------------
	// Reset release
	// -------------------------------------------------------------
	// Two flops release the asynchronous reset on a clock edge.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// -------------------------------------------------------------
	// AXI4-Lite slave
	// -------------------------------------------------------------
	// Write fires once both address and data are held.
	assign rd_word  = reg_read(s_araddr);
	assign old_word = reg_read(aw_addr);
	assign wv       = merge(old_word[31:0], w_data, w_strb);
	assign wr_hit   = old_word[32] && aw_addr != OFF_STAT;
	assign rd_hit   = rd_word[32];
	assign wr_en    = ce && !s_awready && !s_wready && !s_bvalid;

	// Write channels take address and data in either order.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_awready <= 1'b1;
			s_wready <= 1'b1;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OK;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (ce) begin
			if (s_awvalid && s_awready) begin
				aw_addr <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_data <= s_wdata;
				w_strb <= s_wstrb;
				s_wready <= 1'b0;
			end
			if (wr_en) begin
				s_bvalid <= 1'b1;
				s_bresp <= wr_hit ? RESP_OK : RESP_ERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end

	// Read answers on the same edge that takes the address.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_arready <= 1'b1;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= RESP_OK;
		end else if (ce) begin
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid <= 1'b1;
				s_rdata <= rd_word[31:0];
				s_rresp <= rd_hit ? RESP_OK : RESP_ERR;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
				s_arready <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------
	// Software settings
	// -------------------------------------------------------------
	assign req_run  = wr_en && aw_addr == OFF_CTRL && wv[CTL_RUN];
	assign req_stop = wr_en && aw_addr == OFF_CTRL && wv[CTL_STOP];
	assign err_clr  = wr_en && aw_addr == OFF_CTRL && wv[CTL_CLR];

	// Settings registers; the watchdog limit is clamped on write.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			imm_mode <= 1'b0;
			ovr_in <= 16'h0000;
			ovr_out <= 16'h0000;
			prog <= 32'h0000_0000;
			wdt_ms <= WDT_DEF_MS;
			solve_len <= SLEN_RST;
		end else if (wr_en) begin
			if (aw_addr == OFF_CTRL) begin
				imm_mode <= wv[CTL_IMM];
			end else if (aw_addr == OFF_OVR_IN) begin
				ovr_in <= wv[15:0];
			end else if (aw_addr == OFF_OVR_OUT) begin
				ovr_out <= wv[15:0];
			end else if (aw_addr == OFF_PROG) begin
				prog <= wv;
			end else if (aw_addr == OFF_SLEN) begin
				solve_len <= wv[7:0];
			end else if (aw_addr == OFF_WDT) begin
				if (wv[31:14] != 18'h0 || wv[13:0] > WDT_MAX_MS)
					wdt_ms <= WDT_MAX_MS;
				else if (wv[13:0] < WDT_MIN_MS)
					wdt_ms <= WDT_MIN_MS;
				else
					wdt_ms <= wv[13:0];
			end
		end
	end

	// Retentive word has no reset so it survives power-up init.
	always_ff @(posedge sys_clk) begin
		if (wr_en && aw_addr == OFF_RETAIN)
			retain <= wv;
	end

	// Pending forces; a new write wins over consumption.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{fin_pend, fin_msk, fin_val} <= 33'h0;
			{fout_pend, fout_msk, fout_val} <= 33'h0;
		end else if (ce) begin
			if (wr_en && aw_addr == OFF_FRC_IN)
				{fin_pend, fin_msk, fin_val} <= {1'b1, wv};
			else if (seg == SEG_SERVICE)
				fin_pend <= 1'b0;
			if (wr_en && aw_addr == OFF_FRC_OUT)
				{fout_pend, fout_msk, fout_val} <= {1'b1, wv};
			else if (seg == SEG_SOLVE && solve_cnt == 8'h00)
				fout_pend <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// Mode and errors
	// -------------------------------------------------------------
	assign wdt_lim  = 32'(wdt_ms) * 32'(CYC_PER_MS);
	assign wdt_trip = seg == SEG_SOLVE && wdt_cnt >= wdt_lim;

	// Switch position rules; a fatal event always wins.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_mode <= 1'b0;
			sw_q <= 1'b0;
		end else if (ce) begin
			sw_q <= mode_switch_run;
			if (fatal_in || wdt_trip)
				run_mode <= 1'b0;
			else if (!mode_switch_run)
				run_mode <= 1'b0;
			else if (req_stop)
				run_mode <= 1'b0;
			else if ((req_run || !sw_q) && !usb_low_power
				&& !fatal_flag)
				run_mode <= 1'b1;
		end
	end

	// Sticky error flags; a new error wins over a clear.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fatal_flag <= 1'b0;
			nonf_flag <= 1'b0;
			wdt_err <= 1'b0;
			fault <= 1'b0;
		end else if (ce) begin
			fatal_flag <= fatal_in || wdt_trip
				|| (fatal_flag && !err_clr);
			nonf_flag <= nonfatal_in || (nonf_flag && !err_clr);
			wdt_err <= wdt_trip || (wdt_err && !err_clr);
			fault <= fatal_in || wdt_trip || (fatal_flag && !err_clr);
		end
	end

	// -------------------------------------------------------------
	// Scan sequencer
	// -------------------------------------------------------------
	// Segment order with watchdog over the solving segment.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seg <= SEG_INIT;
			solve_cnt <= 8'h00;
			wdt_cnt <= 32'h0000_0000;
		end else if (ce) begin
			case (seg)
			SEG_INIT: seg <= SEG_READ;
			SEG_READ: seg <= SEG_SERVICE;
			SEG_SERVICE: seg <= SEG_SYSTEM;
			SEG_SYSTEM: begin
				solve_cnt <= solve_len + 8'(imm_mode);
				seg <= run_mode ? SEG_SOLVE : SEG_DIAG;
			end
			SEG_SOLVE: begin
				wdt_cnt <= wdt_cnt + 32'h1;
				if (wdt_trip)
					seg <= SEG_DIAG;
				else if (solve_cnt == 8'h00)
					seg <= SEG_WRITE;
				else
					solve_cnt <= solve_cnt - 8'h01;
			end
			SEG_WRITE: seg <= SEG_DIAG;
			SEG_DIAG: begin
				wdt_cnt <= 32'h0000_0000;
				seg <= SEG_READ;
			end
			default: seg <= SEG_INIT;
			endcase
		end
	end

	// Solver result from image or live inputs, masked and inverted by prog.
	assign solved = ((imm_mode ? field_in : in_image) & prog[15:0])
		^ prog[31:16];

	// Input and output images with forcing and override.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_image <= 16'h0000;
			out_image <= 16'h0000;
		end else if (ce) begin
			if (seg == SEG_INIT) begin
				in_image <= 16'h0000;
				out_image <= 16'h0000;
			end else if (seg == SEG_READ) begin
				in_image <= (field_in & ~ovr_in)
					| (in_image & ovr_in);
			end else if (seg == SEG_SERVICE && fin_pend) begin
				in_image <= (in_image & ~fin_msk)
					| (fin_val & fin_msk);
			end else if (seg == SEG_SOLVE && solve_cnt == 8'h00
				&& !wdt_trip) begin
				out_image <= fout_pend
					? (((solved & ~ovr_out) | (out_image & ovr_out))
					& ~fout_msk) | (fout_val & fout_msk)
					: (solved & ~ovr_out) | (out_image & ovr_out);
			end
		end
	end

	// Physical outputs follow the image only in a Run write.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			field_out <= 16'h0000;
		end else if (ce) begin
			if (!run_mode || fatal_in || wdt_trip)
				field_out <= 16'h0000;
			else if (seg == SEG_WRITE)
				field_out <= out_image;
		end
	end

	// Scan statistics and system relays.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_cnt <= 32'h0000_0000;
			scan_avg <= 32'h0000_0000;
			sys_data <= 32'h0000_0000;
			sys_relay <= 7'h00;
			first_scan <= 1'b1;
		end else if (ce) begin
			scan_cnt <= (seg == SEG_DIAG) ? 32'h0 : scan_cnt + 32'h1;
			if (seg == SEG_SYSTEM) begin
				sys_data <= sys_data + 32'h1;
				sys_relay <= {wdt_err, nonf_flag, fatal_flag,
					usb_low_power, mode_switch_run, run_mode,
					first_scan};
			end
			if (seg == SEG_DIAG) begin
				first_scan <= 1'b0;
				scan_avg <= first_scan ? scan_cnt + 32'h1
					: scan_avg - (scan_avg >> AVG_SH)
					+ ((scan_cnt + 32'h1) >> AVG_SH);
			end
		end
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_stop_out_off: assert property (ce && !run_mode |=> field_out == 16'h0)
		else $error("outputs not off in stop");
	a_fatal_stop: assert property (ce && fatal_in |=> !run_mode && fault)
		else $error("fatal error did not stop");
	a_switch_block: assert property (ce && !mode_switch_run |=> !run_mode)
		else $error("run while switch at stop");
	a_low_power: assert property (ce && usb_low_power && !run_mode |=> !run_mode)
		else $error("run entered in low power");
	a_nonfatal_flag: assert property (ce && nonfatal_in |=> nonf_flag)
		else $error("non-fatal error not flagged");
	a_seg_order: assert property (ce && seg == SEG_READ |=> seg == SEG_SERVICE ##0 $past(seg, 1) == SEG_READ)
		else $error("segment order broken");
	a_stop_skip: assert property (ce && seg == SEG_SYSTEM && !run_mode |=> seg == SEG_DIAG)
		else $error("solve in stop mode");
	a_input_read: assert property (ce && seg == SEG_READ && ovr_in == 16'h0 |=> in_image == $past(field_in))
		else $error("input image not captured");
	a_out_write: assert property ($changed(field_out) && field_out != 16'h0 |-> $past(seg) == SEG_WRITE && $past(run_mode))
		else $error("outputs changed outside write");
	a_wdt_trip: assert property (ce && wdt_trip |=> !run_mode && wdt_err && field_out == 16'h0)
		else $error("watchdog trip not handled");
	a_wdt_restart: assert property (ce && seg == SEG_DIAG |=> wdt_cnt == 32'h0)
		else $error("watchdog not restarted");

	c_run_entered: cover property (!run_mode ##1 run_mode);
	c_wdt_trip: cover property (wdt_trip);
	c_force_in: cover property (seg == SEG_SERVICE && fin_pend);
	c_write_run: cover property (seg == SEG_WRITE && run_mode);
endmodule // scs_top
